// >>> logic/ars_cfg.svh
// Constants for the auto-run step sequencer
`ifndef ARS_CFG_SVH
`define ARS_CFG_SVH
// Register indices (word address = index, byte address = 4 * index)
`define ARS_ADDR_MODE      8'h00
`define ARS_ADDR_STATUS    8'h01
`define ARS_ADDR_ACC       8'h02
`define ARS_ADDR_DEC       8'h03
`define ARS_ADDR_FREQ_BASE 8'h10
`define ARS_ADDR_TIME_BASE 8'h20
`define ARS_ADDR_DIR_BASE  8'h30
// Sequencer modes
`define ARS_MODE_OFF       3'h0
`define ARS_MODE_MAX       3'h6
// Directions
`define ARS_DIR_STOP       2'h0
`define ARS_DIR_FWD        2'h1
`define ARS_DIR_REV        2'h2
// Limits
`define ARS_FREQ_MAX       16'h9c40
`define ARS_TIME_MAX       12'he10
// Timing
`define ARS_CLK_HZ         25000000
`define ARS_TICK_S         1
`define ARS_TICK_CYC       (`ARS_CLK_HZ * `ARS_TICK_S)
`endif

// >>> logic/ars_pkg.sv
// Types for the auto-run step sequencer
package ars_pkg;
    typedef enum logic [3:0]
    {
        ARS_IDLE = 4'b0001,
        ARS_RUN  = 4'b0010,
        ARS_HOLD = 4'b0100,
        ARS_DONE = 4'b1000
    } ars_state_t;
endpackage

// >>> logic/ars_ramp.sv
// Frequency ramp generator toward a target
`timescale 1ns/10ps
module ars_ramp
#(
    parameter int FW = 16
)
(
    input  wire logic          ref_clk_in,
    input  wire logic          srst_in,
    input  wire logic          step_in,
    input  wire logic [FW-1:0] target_in,
    input  wire logic [FW-1:0] acc_rate_in,
    input  wire logic [FW-1:0] dec_rate_in,
    output logic      [FW-1:0] freq_out
);
    logic [FW:0] up_sum;
    logic [FW:0] dn_diff;

    // Candidate next values
    assign up_sum  = {1'b0, freq_out} + {1'b0, acc_rate_in};
    assign dn_diff = {1'b0, freq_out} - {1'b0, dec_rate_in};

    // Move toward target once per step pulse, clamped at target
    always_ff @(posedge ref_clk_in)
    begin
        if (srst_in)
            freq_out <= '0;
        else if (step_in && freq_out < target_in)
            freq_out <= (up_sum >= {1'b0, target_in}) ? target_in : up_sum[FW-1:0];
        else if (step_in && freq_out > target_in)
            freq_out <= (dn_diff[FW] || dn_diff[FW-1:0] <= target_in) ? target_in : dn_diff[FW-1:0];
    end
endmodule

// >>> logic/ars_seq.sv
// Auto-run step sequencer top level
// Overview of operation
// - Modes 1 and 4 run each step once in order, then stop output.
// - Modes 2 and 5 wrap to step zero after last step until stopped.
// - Modes 3 and 6 run one cycle then hold final step speed and direction.
// - Modes 1 to 3 resume from interrupted step after stop and rerun.
// - Modes 4 to 6 restart from step zero after stop and rerun.
// - Frequency ramps between steps using selected acceleration and deceleration rates.
// - Step zero target frequency is the keypad frequency setting.
// - Keypad source: enable input high, keypad run and stop keys command.
// - Host source: enable input high, host run and stop commands.
// - Step direction code 0 stop, 1 forward, 2 reverse.
// - Step time 0 to 3600 s; step frequencies 0 to 400 Hz.
//
// The address-and-strobe port and the register addresses are this design's own decisions.
`timescale 1ns/10ps
`include "ars_cfg.svh"
module ars_seq
    import ars_pkg::*;
#(
    parameter int TICK_CYC = `ARS_TICK_CYC,
    parameter int NSTEP    = 16
)
(
    input  wire logic        ref_clk_in,
    input  wire logic        srst_in,
    input  wire logic [7:0]  addr_in,
    input  wire logic [31:0] wdata_in,
    input  wire logic        wr_in,
    input  wire logic        rd_in,
    output logic      [31:0] rdata_out,
    input  wire logic [1:0]  run_source_in,
    input  wire logic        auto_enable_in,
    input  wire logic        key_run_in,
    input  wire logic        key_stop_in,
    input  wire logic        multifunction_input_one_in,
    input  wire logic        host_run_in,
    input  wire logic        host_stop_in,
    input  wire logic [15:0] keypad_freq_in,
    output logic [15:0]      freq_out,
    output logic [15:0]      target_out,
    output logic             forward_rotation_out,
    output logic             reverse_rotation_out,
    output logic             running_out,
    output logic [3:0]       step_out
);
    // ------------------------------------------------------------
    // Storage and synchronisers
    // ------------------------------------------------------------
    logic [2:0]  mode_q;
    logic [15:0] acc_q;
    logic [15:0] dec_q;
    logic [15:0] freq_tab_q [1:NSTEP-1];
    logic [11:0] time_tab_q [0:NSTEP-1];
    logic [1:0]  dir_tab_q  [0:NSTEP-1];
    logic [2:0]  en_sync_q;
    logic [2:0]  term_sync_q;
    logic        en_q;
    logic        term_q;
    logic        term_prev_q;
    ars_state_t  state_q;
    logic [3:0]  step_q;
    logic [11:0] sec_q;
    logic [31:0] tick_cnt_q;
    logic        tick;
    logic        run_cmd;
    logic        stop_cmd;
    logic        last_step;
    logic [3:0]  step_nx;
    logic [15:0] tgt;
    logic [1:0]  dir;
    // Pins pass three flops; change accepted when stages two and three agree
    always_ff @(posedge ref_clk_in)
    begin
        if (srst_in)
        begin
            en_sync_q   <= 3'h0;
            term_sync_q <= 3'h0;
            en_q        <= 1'b0;
            term_q      <= 1'b0;
            term_prev_q <= 1'b0;
        end
        else
        begin
            en_sync_q   <= {en_sync_q[1:0], auto_enable_in};
            term_sync_q <= {term_sync_q[1:0], multifunction_input_one_in};
            if (en_sync_q[1] == en_sync_q[2])
                en_q <= en_sync_q[2];
            if (term_sync_q[1] == term_sync_q[2])
                term_q <= term_sync_q[2];
            term_prev_q <= term_q;
        end
    end
    // ------------------------------------------------------------
    // Register port
    // ------------------------------------------------------------
    // Writes; over-range frequency and time values clamp to the documented limits, an over-range mode selects off
    always_ff @(posedge ref_clk_in)
    begin
        if (srst_in)
        begin
            mode_q <= `ARS_MODE_OFF;
            acc_q  <= 16'h0001;
            dec_q  <= 16'h0001;
            for (int i = 0; i < NSTEP; i++)
            begin
                if (i > 0)
                    freq_tab_q[i] <= 16'h0000;
                time_tab_q[i] <= 12'h000;
                dir_tab_q[i]  <= `ARS_DIR_STOP;
            end
        end
        else if (wr_in)
        begin
            if (addr_in == `ARS_ADDR_MODE)
                mode_q <= (wdata_in[2:0] > `ARS_MODE_MAX) ? `ARS_MODE_OFF : wdata_in[2:0];
            else if (addr_in == `ARS_ADDR_ACC)
                acc_q <= wdata_in[15:0];
            else if (addr_in == `ARS_ADDR_DEC)
                dec_q <= wdata_in[15:0];
            else if (addr_in[7:4] == `ARS_ADDR_FREQ_BASE >> 4 && addr_in[3:0] != 4'h0)
                freq_tab_q[addr_in[3:0]] <= (wdata_in[15:0] > `ARS_FREQ_MAX) ? `ARS_FREQ_MAX : wdata_in[15:0];
            else if (addr_in[7:4] == `ARS_ADDR_TIME_BASE >> 4)
                time_tab_q[addr_in[3:0]] <= (wdata_in[31:12] != 20'h0 || wdata_in[11:0] > `ARS_TIME_MAX)
                                            ? `ARS_TIME_MAX : wdata_in[11:0];
            else if (addr_in[7:4] == `ARS_ADDR_DIR_BASE >> 4)
                dir_tab_q[addr_in[3:0]] <= wdata_in[1:0];
        end
    end
    // Reads, data valid the cycle after the strobe; unmapped read zero
    always_ff @(posedge ref_clk_in)
    begin
        if (srst_in || !rd_in)
            rdata_out <= 32'h0;
        else if (addr_in == `ARS_ADDR_MODE)
            rdata_out <= {29'h0, mode_q};
        else if (addr_in == `ARS_ADDR_STATUS)
            rdata_out <= {12'h0, sec_q, step_q, state_q};
        else if (addr_in == `ARS_ADDR_ACC)
            rdata_out <= {16'h0, acc_q};
        else if (addr_in == `ARS_ADDR_DEC)
            rdata_out <= {16'h0, dec_q};
        else if (addr_in[7:4] == `ARS_ADDR_FREQ_BASE >> 4)
            rdata_out <= {16'h0, (addr_in[3:0] == 4'h0) ? keypad_freq_in : freq_tab_q[addr_in[3:0]]};
        else if (addr_in[7:4] == `ARS_ADDR_TIME_BASE >> 4)
            rdata_out <= {20'h0, time_tab_q[addr_in[3:0]]};
        else if (addr_in[7:4] == `ARS_ADDR_DIR_BASE >> 4)
            rdata_out <= {30'h0, dir_tab_q[addr_in[3:0]]};
        else
            rdata_out <= 32'h0;
    end
    // ------------------------------------------------------------
    // Command decode
    // ------------------------------------------------------------
    // Run by source, valid only while enable is closed and mode is not off; stop by source or by open enable
    always_comb
    begin
        run_cmd  = 1'b0;
        stop_cmd = !en_q;
        case (run_source_in)
            2'h0:
            begin
                run_cmd  = en_q && key_run_in;
                stop_cmd = stop_cmd || key_stop_in;
            end
            2'h1:
            begin
                run_cmd  = en_q && term_q && !term_prev_q;
                stop_cmd = stop_cmd || (!term_q && term_prev_q);
            end
            default:
            begin
                run_cmd  = en_q && host_run_in;
                stop_cmd = stop_cmd || host_stop_in;
            end
        endcase
        if (mode_q == `ARS_MODE_OFF)
            run_cmd = 1'b0;
    end
    // One-second tick, restarted whenever the sequencer leaves the run state
    always_ff @(posedge ref_clk_in)
    begin
        if (srst_in || state_q != ARS_RUN || tick_cnt_q == 32'(TICK_CYC - 1))
            tick_cnt_q <= 32'h0;
        else
            tick_cnt_q <= tick_cnt_q + 32'h1;
    end
    assign tick = (state_q == ARS_RUN) && (tick_cnt_q == 32'(TICK_CYC - 1));
    // zero time or table end closes the cycle
    assign step_nx   = step_q + 4'h1;
    assign last_step = (step_q == 4'(NSTEP - 1)) || (time_tab_q[step_nx] == 12'h000);
    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_in)
    begin
        if (srst_in)
        begin
            state_q <= ARS_IDLE;
            step_q  <= 4'h0;
            sec_q   <= 12'h000;
        end
        else
        begin
            case (state_q)
                ARS_IDLE, ARS_DONE:
                    if (run_cmd)
                    begin
                        state_q <= ARS_RUN;
                        // fresh cycle in modes 4 to 6 and after done; modes 1 to 3 resume from idle
                        if (mode_q >= 3'h4 || state_q == ARS_DONE)
                        begin
                            step_q <= 4'h0;
                            sec_q  <= 12'h000;
                        end
                    end
                ARS_RUN:
                    if (stop_cmd)
                        state_q <= ARS_IDLE;
                    else if (tick && sec_q + 12'h1 < time_tab_q[step_q])
                        sec_q <= sec_q + 12'h1;
                    else if (tick || time_tab_q[step_q] == 12'h000)
                    begin
                        sec_q <= 12'h000;
                        if (!last_step)
                            step_q <= step_nx;
                        else if (mode_q == 3'h2 || mode_q == 3'h5)
                            step_q <= 4'h0;
                        else if (mode_q == 3'h3 || mode_q == 3'h6)
                            state_q <= ARS_HOLD;
                        else
                            state_q <= ARS_DONE;
                    end
                ARS_HOLD:
                    if (stop_cmd)
                        state_q <= ARS_DONE;
                default:
                    state_q <= ARS_IDLE;
            endcase
        end
    end
    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // step zero uses keypad frequency; direction decode
    always_comb
    begin
        tgt = (step_q == 4'h0) ? keypad_freq_in : freq_tab_q[step_q];
        dir = dir_tab_q[step_q];
        if (state_q == ARS_IDLE || state_q == ARS_DONE || dir == `ARS_DIR_STOP || dir > `ARS_DIR_REV)
            tgt = 16'h0000;
    end
    // Registered direction and status
    always_ff @(posedge ref_clk_in)
    begin
        if (srst_in)
        begin
            target_out           <= 16'h0000;
            forward_rotation_out <= 1'b0;
            reverse_rotation_out <= 1'b0;
            running_out          <= 1'b0;
            step_out             <= 4'h0;
        end
        else
        begin
            target_out           <= tgt;
            forward_rotation_out <= (state_q == ARS_RUN || state_q == ARS_HOLD) && dir == `ARS_DIR_FWD;
            reverse_rotation_out <= (state_q == ARS_RUN || state_q == ARS_HOLD) && dir == `ARS_DIR_REV;
            running_out          <= state_q == ARS_RUN || state_q == ARS_HOLD;
            step_out             <= step_q;
        end
    end
    // ramp with selected rates, one step per millisecond
    logic [15:0] ms_cnt_q;
    always_ff @(posedge ref_clk_in)
    begin
        if (srst_in || ms_cnt_q == 16'(TICK_CYC / 1000 > 0 ? TICK_CYC / 1000 - 1 : 0))
            ms_cnt_q <= 16'h0;
        else
            ms_cnt_q <= ms_cnt_q + 16'h1;
    end
    ars_ramp #(.FW(16)) u_ramp (
        .ref_clk_in  (ref_clk_in),
        .srst_in     (srst_in),
        .step_in     (ms_cnt_q == 16'(TICK_CYC / 1000 > 0 ? TICK_CYC / 1000 - 1 : 0)),
        .target_in   (target_out),
        .acc_rate_in (acc_q),
        .dec_rate_in (dec_q),
        .freq_out    (freq_out)
    );
endmodule

// >>> testbench/ars_seq_props.sv
// Port checker for the auto-run sequencer
`timescale 1ns/10ps
module ars_seq_chk
(
    input wire logic        ref_clk_in,
    input wire logic        srst_in,
    input wire logic        rd_in,
    input wire logic [31:0] rdata_out,
    input wire logic        auto_enable_in,
    input wire logic [15:0] keypad_freq_in,
    input wire logic [15:0] freq_out,
    input wire logic [15:0] target_out,
    input wire logic        forward_rotation_out,
    input wire logic        reverse_rotation_out,
    input wire logic        running_out,
    input wire logic [3:0]  step_out
);
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (srst_in);
    // ---------------------------------------
    // Assertions
    // ---------------------------------------
    dir_excl_a: assert property (!(forward_rotation_out && reverse_rotation_out))
        else $error("both directions active");
    stop_tgt_a: assert property (!running_out |-> target_out == 16'h0)
        else $error("target while stopped");
    rd_idle_a: assert property (!$past(rd_in) |-> rdata_out == 32'h0)
        else $error("read data without read");
    ramp_bound_a: assert property ((freq_out <= target_out) |=> freq_out <= $past(target_out))
        else $error("ramp overshoot");
    step0_kp_a: assert property (running_out && $past(running_out) && step_out == 4'h0 && $stable(step_out)
        && $stable(keypad_freq_in) && (forward_rotation_out || reverse_rotation_out)
        |-> target_out == keypad_freq_in)
        else $error("step zero target not keypad");
    freq_lim_a: assert property (step_out != 4'h0 |-> target_out <= 16'h9c40)
        else $error("target above limit");
    en_drop_a: assert property (!auto_enable_in [*8] |=> !running_out)
        else $error("running without enable");
    en_need_a: assert property ($rose(running_out) |-> $past(auto_enable_in, 5))
        else $error("start without enable");
    // Main scenarios
    run_c: cover property ($rose(running_out));
    rev_c: cover property (reverse_rotation_out);
    wrap_c: cover property (step_out == 4'h2 ##1 step_out == 4'h0);
endmodule

// >>> testbench/ars_operator.sv
// Operator model: keypad, terminals and host
`timescale 1ns/10ps
module ars_operator
(
    input  wire logic       ref_clk_in,
    input  wire logic       srst_in,
    input  wire logic [1:0] source_in,
    input  wire logic       close_in,
    input  wire logic       run_req_in,
    input  wire logic       stop_req_in,
    output logic            auto_enable_out,
    output logic            key_run_out,
    output logic            key_stop_out,
    output logic            mfi_one_out,
    output logic            host_run_out,
    output logic            host_stop_out
);
    // Enable contact and keypad keys
    // keypad run stop
    always_ff @(posedge ref_clk_in)
    begin
        auto_enable_out <= close_in;
        key_run_out     <= run_req_in && (source_in == 2'h0);
        key_stop_out    <= stop_req_in && (source_in == 2'h0);
    end
    // Forward/stop level, terminal source 1 only
    // terminal forward stop
    always_ff @(posedge ref_clk_in)
    begin
        if (srst_in)
            mfi_one_out <= 1'b0;
        else if (source_in == 2'h1 && (run_req_in || stop_req_in))
            mfi_one_out <= run_req_in;
    end
    // Host commands over the link
    // host run stop
    always_ff @(posedge ref_clk_in)
    begin
        host_run_out  <= run_req_in && source_in[1];
        host_stop_out <= stop_req_in && source_in[1];
    end
endmodule

// >>> testbench/tb.sv
// Self-checking bench of the auto-run sequencer
`timescale 1ns/10ps
`include "ars_cfg.svh"
module tb;
    localparam int TK = 2000;
    logic        ref_clk_in = 1'b0;
    logic        srst_in = 1'b1;
    logic        wr_in = 1'b0;
    logic        rd_in = 1'b0;
    logic        close = 1'b0;
    logic        run_req = 1'b0;
    logic        stop_req = 1'b0;
    logic [7:0]  addr_in = 8'h00;
    logic [31:0] wdata_in = 32'h0;
    logic [1:0]  run_source_in = 2'h0;
    logic [15:0] keypad_freq_in = 16'h05dc;
    logic [31:0] rdata_out;
    logic [15:0] freq_out;
    logic [15:0] target_out;
    logic [3:0]  step_out;
    logic        forward_rotation_out;
    logic        reverse_rotation_out;
    logic        running_out;
    logic        auto_enable_in;
    logic        key_run_in;
    logic        key_stop_in;
    logic        multifunction_input_one_in;
    logic        host_run_in;
    logic        host_stop_in;
    logic [31:0] d;
    int          num_errors = 0;
    int          total_checks = 0;
    // Clock
    always #20 ref_clk_in = ~ref_clk_in;
    ars_seq #(.TICK_CYC(TK)) u_dut (.ref_clk_in, .srst_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out,
        .run_source_in, .auto_enable_in, .key_run_in, .key_stop_in, .multifunction_input_one_in, .host_run_in,
        .host_stop_in, .keypad_freq_in, .freq_out, .target_out, .forward_rotation_out, .reverse_rotation_out,
        .running_out, .step_out);
    ars_operator u_op (.ref_clk_in, .srst_in, .source_in(run_source_in), .close_in(close), .run_req_in(run_req),
        .stop_req_in(stop_req), .auto_enable_out(auto_enable_in), .key_run_out(key_run_in),
        .key_stop_out(key_stop_in), .mfi_one_out(multifunction_input_one_in), .host_run_out(host_run_in),
        .host_stop_out(host_stop_in));
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e)
        begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge ref_clk_in);
        addr_in <= a;
        wdata_in <= v;
        wr_in <= 1'b1;
        @(posedge ref_clk_in);
        wr_in <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge ref_clk_in);
        addr_in <= a;
        rd_in <= 1'b1;
        @(posedge ref_clk_in);
        rd_in <= 1'b0;
        @(negedge ref_clk_in);
        d = rdata_out;
    endtask
    task automatic cmd(input logic r);
        @(posedge ref_clk_in);
        run_req <= r;
        stop_req <= !r;
        @(posedge ref_clk_in);
        run_req <= 1'b0;
        stop_req <= 1'b0;
    endtask
    task automatic wait_st(input logic [3:0] s);
        for (int i = 0; i < 4 * TK; i++)
        begin
            @(negedge ref_clk_in);
            if (running_out === 1'b1 && step_out === s)
                break;
        end
        chk("step", {1'b1, s}, {running_out, step_out});
    endtask
    task automatic wait_run(input logic r);
        for (int i = 0; i < 4 * TK; i++)
        begin
            @(negedge ref_clk_in);
            if (running_out === r)
                break;
        end
        chk("running", r, running_out);
    endtask
    task automatic t_regs;
        rd(`ARS_ADDR_MODE);
        chk("mode", 0, d);
        wr(`ARS_ADDR_TIME_BASE + 8'h3, 4000);
        rd(`ARS_ADDR_TIME_BASE + 8'h3);
        chk("time", 3600, d);
        wr(`ARS_ADDR_FREQ_BASE + 8'h5, 50000);
        rd(`ARS_ADDR_FREQ_BASE + 8'h5);
        chk("freq", 40000, d);
        wr(`ARS_ADDR_MODE, 7);
        rd(`ARS_ADDR_MODE);
        chk("bad mode", 0, d);
        for (int i = 0; i < 4; i++)
        begin
            wr(`ARS_ADDR_TIME_BASE + 8'(i), (i < 3) ? 1 : 0);
            wr(`ARS_ADDR_DIR_BASE + 8'(i), (i == 1) ? 2 : 1);
        end
        wr(`ARS_ADDR_FREQ_BASE + 8'h1, 3000);
        wr(`ARS_ADDR_FREQ_BASE + 8'h2, 2000);
        wr(`ARS_ADDR_ACC, 10);
        wr(`ARS_ADDR_DEC, 10);
    endtask
    task automatic t_single(input logic [2:0] m, input logic [1:0] s);
        wr(`ARS_ADDR_MODE, m);
        run_source_in <= s;
        cmd(1'b1);
        wait_st(0);
        chk("kp target", {1'b1, 16'h05dc}, {forward_rotation_out, target_out});
        wait_st(1);
        chk("rev", 2'b01, {forward_rotation_out, reverse_rotation_out});
        chk("ramping", 1, freq_out !== 16'd3000);
        wait_run(1'b0);
    endtask
    task automatic t_periodic(input logic [2:0] m);
        wr(`ARS_ADDR_MODE, m);
        run_source_in <= 2'h1;
        cmd(1'b1);
        wait_st(2);
        wait_st(0);
        cmd(1'b0);
        wait_run(1'b0);
    endtask
    task automatic t_hold(input logic [2:0] m);
        wr(`ARS_ADDR_MODE, m);
        run_source_in <= 2'h2;
        cmd(1'b1);
        wait_st(2);
        repeat (3 * TK) @(negedge ref_clk_in);
        chk("hold", {1'b1, 4'h2, 1'b1, 16'd2000}, {running_out, step_out, forward_rotation_out, target_out});
        chk("hold freq", 16'h07d0, freq_out);
        cmd(1'b0);
        wait_run(1'b0);
    endtask
    task automatic t_resume(input logic [2:0] m, input logic [3:0] e);
        wr(`ARS_ADDR_MODE, m);
        run_source_in <= 2'h0;
        cmd(1'b1);
        wait_st(1);
        cmd(1'b0);
        wait_run(1'b0);
        cmd(1'b1);
        wait_run(1'b1);
        chk("restart", e, step_out);
        cmd(1'b0);
        wait_run(1'b0);
    endtask
    task automatic t_enable;
        wr(`ARS_ADDR_MODE, 2);
        cmd(1'b1);
        wait_st(0);
        @(posedge ref_clk_in);
        close <= 1'b0;
        wait_run(1'b0);
        @(posedge ref_clk_in);
        close <= 1'b1;
    endtask
    task automatic final_report;
        if (num_errors == 0 && total_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // Main sequence
    initial
    begin
        repeat (10) @(posedge ref_clk_in);
        srst_in <= 1'b0;
        close <= 1'b1;
        t_regs();
        repeat (8) @(posedge ref_clk_in);
        t_single(3'h1, 2'h0);
        t_single(3'h4, 2'h2);
        t_periodic(3'h2);
        t_periodic(3'h5);
        t_hold(3'h6);
        t_hold(3'h3);
        t_resume(3'h1, 4'h1);
        t_resume(3'h4, 4'h0);
        t_enable();
        final_report();
    end
    // Watchdog
    initial
    begin
        repeat (90000) @(posedge ref_clk_in);
        num_errors++;
        final_report();
    end
endmodule
bind ars_seq ars_seq_chk u_chk (.ref_clk_in, .srst_in, .rd_in, .rdata_out, .auto_enable_in, .keypad_freq_in,
    .freq_out, .target_out, .forward_rotation_out, .reverse_rotation_out, .running_out, .step_out);
